// >>> hdl/alarm_pkg.sv
// alarm_pkg: shared constants, command codes and carriers for the alarm block.
// assumes a single 200 MHz clock domain and the host command port of alarm_top.
package alarm_pkg;

    localparam int WORD_W  = 16;
    localparam int POINT_N = 4;

    // alarm word bit positions
    localparam int BIT_POS_LIMIT = 0;
    localparam int BIT_CCW_LIMIT = 1;
    localparam int BIT_CW_LIMIT  = 2;
    localparam int BIT_OVER_TEMP = 3;
    localparam int BIT_REGEN     = 4;
    localparam int BIT_OVER_VOLT = 5;
    localparam int BIT_UNDER_VLT = 6;
    localparam int BIT_OVER_CUR  = 7;
    localparam int BIT_OPEN_WIND = 8;
    localparam int BIT_COMM_ERR  = 10;
    localparam int BIT_BAD_FLASH = 11;
    localparam int BIT_NO_MOVE   = 12;
    localparam int BIT_BLANK_SEG = 14;

    localparam logic [15:0] ONE_HOT = 16'h0001;
    localparam logic [15:0] FAULT_MASK =
        (ONE_HOT << BIT_POS_LIMIT) | (ONE_HOT << BIT_OVER_TEMP) | (ONE_HOT << BIT_REGEN) |
        (ONE_HOT << BIT_OVER_VOLT) | (ONE_HOT << BIT_OVER_CUR) | (ONE_HOT << BIT_OPEN_WIND);
    localparam logic [15:0] ALARM_USED_MASK = FAULT_MASK |
        (ONE_HOT << BIT_CCW_LIMIT) | (ONE_HOT << BIT_CW_LIMIT) | (ONE_HOT << BIT_UNDER_VLT) |
        (ONE_HOT << BIT_COMM_ERR) | (ONE_HOT << BIT_BAD_FLASH) | (ONE_HOT << BIT_NO_MOVE) |
        (ONE_HOT << BIT_BLANK_SEG);

    // drive condition word fields
    localparam int COND_ENABLE_BIT = 0;
    localparam int COND_FAULT_BIT  = 2;

    // fault pin configuration codes
    localparam logic [1:0] PIN_CFG_CLOSE  = 2'h1;
    localparam logic [1:0] PIN_CFG_OPEN   = 2'h2;
    localparam logic [1:0] PIN_CFG_UNUSED = 2'h3;

    // pin levels: energized is low (closed), idle is high (open)
    localparam logic LEVEL_LOW  = 1'b0;
    localparam logic LEVEL_HIGH = 1'b1;
    localparam logic [7:0] CHAR_LOW  = 8'h4c;
    localparam logic [7:0] CHAR_HIGH = 8'h48;

    // peak rate limit in sixths of rev/s/s
    localparam logic [15:0] RATE_MIN   = 16'h0001;
    localparam logic [15:0] RATE_MAX   = 16'h7fff;
    localparam logic [15:0] RATE_RESET = 16'h0258;

    localparam logic [2:0] POINT_MIN   = 3'h1;
    localparam logic [2:0] POINT_MAX   = 3'h4;
    localparam logic [2:0] POINT_RESET = 3'h1;

    localparam logic [7:0] CHAR_ZERO     = 8'h30;
    localparam logic [7:0] CHAR_ALPHA    = 8'h37;
    localparam logic [3:0] NIBBLE_DECIMAL = 4'h9;

    typedef enum logic [3:0] {
        CMD_READ_FAULT_WORD, CMD_READ_CONDITION, CMD_READ_PIN_CONFIG, CMD_READ_RATE,
        CMD_SET_PIN_CONFIG, CMD_SET_BRAKE_FUNC, CMD_SET_TRAVEL_FUNC, CMD_SET_TACH_FUNC,
        CMD_SET_GENERAL_FUNC, CMD_SET_IO_DIR, CMD_SET_OUT_LEVEL, CMD_SET_RATE,
        CMD_HALT, CMD_HALT_KILL, CMD_FAULT_CLEAR, CMD_DRIVE_ENABLE
    } cmd_e;

    typedef enum logic [2:0] {
        FUNC_ALARM, FUNC_BRAKE, FUNC_MOTION, FUNC_TACH, FUNC_GENERAL
    } out_func_e;

    typedef struct packed {
        cmd_e        code;
        logic [15:0] arg;
        logic [2:0]  point;
        logic [7:0]  level_char;
    } cmd_s;

    typedef struct packed {
        logic [15:0] word;
        logic [31:0] hex;
    } rsp_s;

endpackage

// >>> hdl/alarm_latch.sv
// alarm_latch: sticky alarm bits, cleared only where the condition has gone.
// assumes cond is already synchronised to CLOCK.
module alarm_latch #(
    parameter int          WIDTH = 16,
    parameter logic [15:0] USED  = 16'hffff
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] cond,
    input  wire logic             clear,
    output logic      [WIDTH-1:0] word
);
    // one sticky flop per USED bit, other bits held at zero; a live condition beats the clear
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge clock) begin
            if (rst || !USED[i]) begin
                word[i] <= 1'b0;
            end else begin
                word[i] <= cond[i] | (word[i] & ~clear);
            end
        end
    end
endmodule

// >>> hdl/hex_encoder.sv
// hex_encoder: turns a 16-bit word into four ASCII hex digits, high digit first.
// assumes a purely combinational use; the caller registers the result.
module hex_encoder (
    input  wire logic [15:0] word,
    output logic      [31:0] hex
);
    import alarm_pkg::*;

    // one digit per nibble, upper case letters
    for (genvar n = 0; n < 4; n++) begin : g_digit
        logic [3:0] nib;
        assign nib = word[4*n +: 4];
        assign hex[8*n +: 8] = (nib > NIBBLE_DECIMAL) ? CHAR_ALPHA + {4'h0, nib}
                                                      : CHAR_ZERO + {4'h0, nib};
    end
endmodule

// >>> hdl/alarm_top.sv
// alarm_top: alarm word, fault status, shared alarm output pin and peak rate limit.
// assumes a command parser delivers decoded commands in the CLOCK domain and that
// alarm conditions arrive as raw pin-level signals from outside.
// How it works
// (R1) alarm word query returns four hex digits
// (R2) bits 0-2 hold limit alarms
// (R3) bits 3-7 hold thermal, voltage, current alarms
// (R4) bits 8-14 hold other alarms, rest reserved
// (R5) only six alarms count as faults
// (R6) peak rate applies in analog velocity mode
// (R7) peak rate used for limits and halts
// (R8) output pin serves exactly one function
// (R9) code 1 closes pin on fault
// (R10) code 2 opens pin on fault
// (R11) code 3 frees pin for others
// (R12) point 1-4 carries alarm, must be output
// (R13) brake or travel function reclaims pin, code 3
// (R14) energized means low, idle means high
// (R15) characters L and H name levels
// (R16) fault clear drops gone alarms, stays disabled
// (R17) alarm bits stay until cleared
// (R18) pin level follows fault state continuously
module alarm_top #(
    parameter logic [15:0] RATE_DEFAULT = alarm_pkg::RATE_RESET,
    parameter bit          VARIABLE_IO  = 1'b1
) (
    // clock and reset
    input  wire logic                      CLOCK,
    input  wire logic                      RST,
    // host command port
    input  wire logic                      CMD_VALID,
    input  wire alarm_pkg::cmd_s           CMD,
    output logic                           RSP_VALID,
    output alarm_pkg::rsp_s                RSP,
    // raw alarm conditions from the power stage
    input  wire logic [15:0]               ALARM_COND,
    // motion context
    input  wire logic                      ANALOG_VEL_MODE,
    input  wire logic                      FEED_ACTIVE,
    input  wire logic                      MOTION_ACTIVE,
    input  wire logic                      BRAKE_LEVEL,
    input  wire logic                      TACH_LEVEL,
    // motion control
    output logic                           USE_PEAK_RATE,
    output logic [15:0]                    PEAK_RATE,
    output logic                           HALT_PULSE,
    output logic                           KILL_PULSE,
    output logic                           DRIVE_ENABLED,
    // io points
    output logic [3:0]                     IO_OUT,
    output logic [3:0]                     IO_OE
);
    import alarm_pkg::*;

    logic [15:0] cond_meta_reg;
    logic [15:0] cond_sync_reg;
    logic [15:0] fault_word;
    logic        fault_now;
    logic [15:0] cond_word;
    logic        clear_pulse;
    logic [1:0]  pin_cfg_reg;
    logic [2:0]  func_point_reg;
    out_func_e   func_reg;
    logic [3:0]  dir_reg;
    logic [3:0]  gp_level_reg;
    logic [15:0] rate_reg;
    logic        stop_hold_reg;
    logic        drive_en_reg;
    logic        func_level;
    logic [1:0]  pt_idx;
    logic [15:0] rsp_word;
    logic [31:0] rsp_hex;
    logic        is_read;
    logic        point_ok;
    logic        travel_limit;

    // two-flop synchroniser for the asynchronous alarm conditions
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            cond_meta_reg <= 16'h0000;
            cond_sync_reg <= 16'h0000;
        end else begin
            cond_meta_reg <= ALARM_COND;
            cond_sync_reg <= cond_meta_reg;
        end
    end

    assign clear_pulse = CMD_VALID && CMD.code == CMD_FAULT_CLEAR;

    // (R2) (R3) (R4) one sticky bit per alarm
    // (R17) sticky alarm bits
    // (R16) clear spares persisting alarms
    alarm_latch #(
        .WIDTH (WORD_W),
        .USED  (ALARM_USED_MASK)
    ) u_latch (
        .clock (CLOCK),
        .rst   (RST),
        .cond  (cond_sync_reg),
        .clear (clear_pulse),
        .word  (fault_word)
    );

    // (R5) fault subset only
    assign fault_now = |(fault_word & FAULT_MASK);

    // condition word: fault and enable flags, all else zero
    always_comb begin
        cond_word = 16'h0000;
        cond_word[COND_FAULT_BIT]  = fault_now;
        cond_word[COND_ENABLE_BIT] = drive_en_reg;
    end

    // (R16) clear never re-enables; a fault always disables
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            drive_en_reg <= 1'b0;
        end else if (fault_now) begin
            drive_en_reg <= 1'b0;
        end else if (CMD_VALID && CMD.code == CMD_DRIVE_ENABLE) begin
            drive_en_reg <= 1'b1;
        end
    end
    assign DRIVE_ENABLED = drive_en_reg;

    // standard io drives carry the function on point 1 only
    assign point_ok = VARIABLE_IO ? (CMD.point >= POINT_MIN && CMD.point <= POINT_MAX)
                                  : (CMD.point == POINT_MIN);

    // output function ownership; one owner at a time since it is a single state
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            func_reg       <= FUNC_GENERAL;
            pin_cfg_reg    <= PIN_CFG_UNUSED;
            func_point_reg <= POINT_RESET;
        end else if (CMD_VALID && point_ok) begin
            unique case (CMD.code)
                CMD_SET_PIN_CONFIG: begin
                    // (R9) (R10) codes 1 and 2 override
                    if (CMD.arg[1:0] == PIN_CFG_CLOSE || CMD.arg[1:0] == PIN_CFG_OPEN) begin
                        pin_cfg_reg    <= CMD.arg[1:0];
                        func_reg       <= FUNC_ALARM;
                        func_point_reg <= CMD.point;
                    // (R11) code 3 releases the pin
                    end else if (CMD.arg[1:0] == PIN_CFG_UNUSED) begin
                        pin_cfg_reg <= PIN_CFG_UNUSED;
                        if (func_reg == FUNC_ALARM) begin
                            func_reg <= FUNC_GENERAL;
                        end
                    end
                end
                // (R13) brake takes pin, code 3
                CMD_SET_BRAKE_FUNC: begin
                    func_reg       <= FUNC_BRAKE;
                    pin_cfg_reg    <= PIN_CFG_UNUSED;
                    func_point_reg <= CMD.point;
                end
                // (R13) travel takes pin, code 3
                CMD_SET_TRAVEL_FUNC: begin
                    func_reg       <= FUNC_MOTION;
                    pin_cfg_reg    <= PIN_CFG_UNUSED;
                    func_point_reg <= CMD.point;
                end
                // (R8) others wait until alarm releases
                CMD_SET_TACH_FUNC, CMD_SET_GENERAL_FUNC: begin
                    if (pin_cfg_reg == PIN_CFG_UNUSED) begin
                        func_reg       <= (CMD.code == CMD_SET_TACH_FUNC) ? FUNC_TACH
                                                                          : FUNC_GENERAL;
                        func_point_reg <= CMD.point;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // io direction setup: a set bit makes the point an output
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            dir_reg <= 4'h0;
        end else if (CMD_VALID && CMD.code == CMD_SET_IO_DIR) begin
            dir_reg <= CMD.arg[3:0];
        end
    end

    // (R15) L and H select level
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            gp_level_reg <= {POINT_N{LEVEL_HIGH}};
        end else if (CMD_VALID && CMD.code == CMD_SET_OUT_LEVEL && point_ok) begin
            if (CMD.level_char == CHAR_LOW) begin
                gp_level_reg[2'(CMD.point - POINT_MIN)] <= LEVEL_LOW;
            end else if (CMD.level_char == CHAR_HIGH) begin
                gp_level_reg[2'(CMD.point - POINT_MIN)] <= LEVEL_HIGH;
            end
        end
    end

    assign pt_idx = 2'(func_point_reg - POINT_MIN);

    // (R18) level tracks live fault state
    // (R14) active means driven low
    always_comb begin
        unique case (func_reg)
            FUNC_ALARM: begin
                if (pin_cfg_reg == PIN_CFG_CLOSE) begin
                    func_level = fault_now ? LEVEL_LOW : LEVEL_HIGH;
                end else begin
                    func_level = fault_now ? LEVEL_HIGH : LEVEL_LOW;
                end
            end
            FUNC_BRAKE:   func_level = BRAKE_LEVEL ? LEVEL_LOW : LEVEL_HIGH;
            FUNC_MOTION:  func_level = MOTION_ACTIVE ? LEVEL_LOW : LEVEL_HIGH;
            FUNC_TACH:    func_level = TACH_LEVEL;
            FUNC_GENERAL: func_level = gp_level_reg[pt_idx];
            default:      func_level = LEVEL_HIGH;
        endcase
    end

    // (R12) function only on its point, driven if output
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            IO_OUT <= {POINT_N{LEVEL_HIGH}};
            IO_OE  <= 4'h0;
        end else begin
            for (int i = 0; i < POINT_N; i++) begin
                IO_OUT[i] <= (pt_idx == 2'(i)) ? func_level : gp_level_reg[i];
            end
            IO_OE <= dir_reg;
        end
    end

    // (R6) peak rate stored within range; out-of-range writes clamp
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            rate_reg <= RATE_DEFAULT;
        end else if (CMD_VALID && CMD.code == CMD_SET_RATE) begin
            if (CMD.arg < RATE_MIN) begin
                rate_reg <= RATE_MIN;
            end else if (CMD.arg > RATE_MAX) begin
                rate_reg <= RATE_MAX;
            end else begin
                rate_reg <= CMD.arg;
            end
        end
    end
    assign PEAK_RATE = rate_reg;

    assign travel_limit = cond_sync_reg[BIT_CCW_LIMIT] | cond_sync_reg[BIT_CW_LIMIT];

    // (R7) hold peak decel until motion ends; a new stop beats the release
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            stop_hold_reg <= 1'b0;
        end else if ((CMD_VALID && (CMD.code == CMD_HALT || CMD.code == CMD_HALT_KILL))
                     || (FEED_ACTIVE && travel_limit)) begin
            stop_hold_reg <= 1'b1;
        end else if (!MOTION_ACTIVE) begin
            stop_hold_reg <= 1'b0;
        end
    end

    // (R6) (R7) peak rate selection
    assign USE_PEAK_RATE = ANALOG_VEL_MODE | stop_hold_reg;

    // halt strobes for the motion core
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            HALT_PULSE <= 1'b0;
            KILL_PULSE <= 1'b0;
        end else begin
            HALT_PULSE <= CMD_VALID && (CMD.code == CMD_HALT || CMD.code == CMD_HALT_KILL);
            KILL_PULSE <= CMD_VALID && CMD.code == CMD_HALT_KILL;
        end
    end

    // read answers; config reads as code digit then point digit
    always_comb begin
        is_read  = 1'b1;
        rsp_word = 16'h0000;
        unique case (CMD.code)
            CMD_READ_FAULT_WORD: rsp_word = fault_word;
            CMD_READ_CONDITION:  rsp_word = cond_word;
            CMD_READ_PIN_CONFIG: rsp_word = {8'h00, 2'h0, pin_cfg_reg, 1'b0, func_point_reg};
            CMD_READ_RATE:       rsp_word = rate_reg;
            default:             is_read = 1'b0;
        endcase
    end

    hex_encoder u_hex (
        .word (rsp_word),
        .hex  (rsp_hex)
    );

    // (R1) immediate four-digit reply
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            RSP_VALID <= 1'b0;
            RSP       <= '0;
        end else begin
            RSP_VALID <= CMD_VALID && is_read;
            if (CMD_VALID && is_read) begin
                RSP <= '{word: rsp_word, hex: rsp_hex};
            end
        end
    end

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);

    a_fault_word_read: assert property ( // (R1)
        CMD_VALID && CMD.code == CMD_READ_FAULT_WORD |=> RSP_VALID && RSP.word == $past(fault_word)
    ) else $error("fault word reply wrong");

    a_reserved_bits_zero: assert property ( // (R4)
        (fault_word & ~ALARM_USED_MASK) == 16'h0000
    ) else $error("reserved alarm bit set");

    a_limit_latched: assert property ( // (R2)
        cond_sync_reg[BIT_CCW_LIMIT] |=> fault_word[BIT_CCW_LIMIT]
    ) else $error("ccw limit not latched");

    a_fault_status_bit: assert property ( // (R5)
        CMD_VALID && CMD.code == CMD_READ_CONDITION
        |=> RSP.word[COND_FAULT_BIT] == |($past(fault_word) & FAULT_MASK)
    ) else $error("fault status bit wrong");

    a_close_on_fault: assert property ( // (R9)
        func_reg == FUNC_ALARM && pin_cfg_reg == PIN_CFG_CLOSE && fault_now
        |=> IO_OUT[$past(pt_idx)] == LEVEL_LOW
    ) else $error("alarm pin not closed");

    a_open_on_fault: assert property ( // (R10)
        func_reg == FUNC_ALARM && pin_cfg_reg == PIN_CFG_OPEN && fault_now
        |=> IO_OUT[$past(pt_idx)] == LEVEL_HIGH
    ) else $error("alarm pin not open");

    a_brake_reclaims: assert property ( // (R13)
        CMD_VALID && CMD.code == CMD_SET_BRAKE_FUNC && point_ok
        |=> func_reg == FUNC_BRAKE && pin_cfg_reg == PIN_CFG_UNUSED
    ) else $error("brake did not reclaim pin");

    a_halt_peak_rate: assert property ( // (R7)
        CMD_VALID && CMD.code == CMD_HALT |=> USE_PEAK_RATE && HALT_PULSE
    ) else $error("halt not using peak rate");

    a_clear_keeps_live: assert property ( // (R16)
        clear_pulse && cond_sync_reg[BIT_OVER_TEMP] |=> fault_word[BIT_OVER_TEMP] && !DRIVE_ENABLED
    ) else $error("persisting alarm was cleared");

    a_rate_in_range: assert property ( // (R6)
        PEAK_RATE >= RATE_MIN && PEAK_RATE <= RATE_MAX
    ) else $error("peak rate out of range");

    c_fault_read: cover property (CMD_VALID && CMD.code == CMD_READ_FAULT_WORD && fault_now);
    c_alarm_close: cover property (func_reg == FUNC_ALARM && fault_now);
    c_clear_done: cover property (clear_pulse ##1 fault_word == 16'h0000);
    c_limit_stop: cover property (FEED_ACTIVE && travel_limit ##1 stop_hold_reg);
endmodule

// >>> testbench/host_model.sv
// host_model: host side that issues decoded commands and collects replies.
// assumes alarm_top takes CMD at the rising CLOCK edge while CMD_VALID is high.
module host_model (
    // clock
    input  wire logic            CLOCK,
    // command side
    output logic                 CMD_VALID,
    output alarm_pkg::cmd_s      CMD,
    // reply side
    input  wire logic            RSP_VALID,
    input  wire alarm_pkg::rsp_s RSP
);
    timeunit 1ns;
    timeprecision 100ps;
    import alarm_pkg::*;

    // idle bus at time zero
    initial begin
        CMD_VALID = 1'b0;
        CMD = '0;
    end

    // point and level char
    // holds a command for one taking edge; the released bus shows the inverse, never stale data
    task automatic send(input cmd_e c, input logic [15:0] a, input logic [2:0] p,
                        input logic [7:0] ch);
        @(posedge CLOCK);
        CMD_VALID <= 1'b1;
        CMD <= '{code: c, arg: a, point: p, level_char: ch};
        @(posedge CLOCK);
        CMD_VALID <= 1'b0;
        CMD <= ~CMD;
    endtask

    // query with a bounded wait for the reply strobe
    task automatic query(input cmd_e c, output logic ok, output rsp_s r);
        send(c, 16'h0000, POINT_MIN, CHAR_HIGH);
        ok = 1'b0;
        for (int i = 0; i < 4 && !ok; i++) begin
            #1;
            if (RSP_VALID === 1'b1) begin
                ok = 1'b1;
                r = RSP;
            end else @(posedge CLOCK);
        end
    endtask
endmodule

// >>> testbench/testbench.sv
// testbench: drives alarm_top through host_model against a bench model of the word.
// assumes package alarm_pkg and one 200 MHz clock; waits are bounded.
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import alarm_pkg::*;

    logic        CLOCK, RST, CMD_VALID, RSP_VALID, ANALOG_VEL_MODE, FEED_ACTIVE;
    logic        MOTION_ACTIVE, BRAKE_LEVEL, TACH_LEVEL, USE_PEAK_RATE, HALT_PULSE;
    logic        KILL_PULSE, DRIVE_ENABLED, ok, en;
    cmd_s        CMD;
    rsp_s        RSP, r;
    logic [15:0] ALARM_COND, PEAK_RATE, ew, v;
    logic [3:0]  IO_OUT, IO_OE;
    int          n_fail, checked, seed;

    alarm_top dut (.CLOCK(CLOCK), .RST(RST), .CMD_VALID(CMD_VALID), .CMD(CMD),
        .RSP_VALID(RSP_VALID), .RSP(RSP), .ALARM_COND(ALARM_COND),
        .ANALOG_VEL_MODE(ANALOG_VEL_MODE), .FEED_ACTIVE(FEED_ACTIVE),
        .MOTION_ACTIVE(MOTION_ACTIVE), .BRAKE_LEVEL(BRAKE_LEVEL), .TACH_LEVEL(TACH_LEVEL),
        .USE_PEAK_RATE(USE_PEAK_RATE), .PEAK_RATE(PEAK_RATE), .HALT_PULSE(HALT_PULSE),
        .KILL_PULSE(KILL_PULSE), .DRIVE_ENABLED(DRIVE_ENABLED), .IO_OUT(IO_OUT),
        .IO_OE(IO_OE));
    host_model host (.CLOCK(CLOCK), .CMD_VALID(CMD_VALID), .CMD(CMD),
        .RSP_VALID(RSP_VALID), .RSP(RSP));

    // 200 MHz clock
    always #2.5 CLOCK = ~CLOCK;

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic bad(input string m);
        n_fail++;
        $display("unexpected at %0t: %s", $time, m);
    endtask
    task automatic check_word(input logic [15:0] g, input logic [15:0] e, input string m);
        checked++;
        if (g !== e) bad($sformatf("%s got %h want %h", m, g, e));
    endtask
    task automatic check_bit(input logic g, input logic e, input string m);
        checked++;
        if (g !== e) bad($sformatf("%s got %b want %b", m, g, e));
    endtask
    // hex digits worked out here, high digit first
    task automatic check_hex(input logic [31:0] g, input logic [15:0] w);
        logic [31:0] e;
        logic [3:0]  d;
        for (int i = 0; i < 4; i++) begin
            d = w[4*i +: 4];
            e[8*i +: 8] = (d > 4'h9) ? 8'h37 + d : 8'h30 + d;
        end
        checked++;
        if (g !== e) bad($sformatf("hex got %h want %h", g, e));
    endtask
    task automatic read(input cmd_e c);
        host.query(c, ok, r);
        if (ok !== 1'b1) begin
            bad("no reply");
            report_and_stop();
        end
    endtask
    // writes settle within two edges; three are given
    task automatic cmd(input cmd_e c, input logic [15:0] a, input logic [2:0] p,
                       input logic [7:0] ch);
        host.send(c, a, p, ch);
        repeat (3) @(posedge CLOCK);
        #1;
    endtask
    // conditions pass a two-flop synchroniser before latching
    task automatic raise(input logic [15:0] c);
        @(posedge CLOCK);
        ALARM_COND <= c;
        repeat (5) @(posedge CLOCK);
        #1;
        ew = ew | (c & 16'h5dff);
        if ((c & 16'h01b9) != 16'h0) en = 1'b0;
    endtask
    task automatic check_all();
        read(CMD_READ_FAULT_WORD);
        check_word(r.word, ew, "alarm word");
        check_hex(r.hex, ew);
        read(CMD_READ_CONDITION);
        check_word(r.word & 16'h0005, {13'h0, |(ew & 16'h01b9), 1'b0, en}, "cond");
        check_bit(DRIVE_ENABLED, en, "enabled");
    endtask

    // main sequence
    initial begin
        seed = 32'h03013147;
        n_fail = 0;
        checked = 0;
        ew = 16'h0;
        en = 1'b0;
        CLOCK = 1'b0;
        RST = 1'b1;
        ALARM_COND = 16'h0;
        ANALOG_VEL_MODE = 1'b0;
        FEED_ACTIVE = 1'b0;
        MOTION_ACTIVE = 1'b0;
        BRAKE_LEVEL = 1'b0;
        TACH_LEVEL = 1'b0;
        repeat (10) @(posedge CLOCK);
        RST <= 1'b0;
        @(posedge CLOCK);
        #1;
        check_word(PEAK_RATE, 16'h0258, "rate reset");
        check_word({8'h0, IO_OUT, IO_OE}, 16'h00f0, "pins reset");
        check_all();
        read(CMD_READ_PIN_CONFIG);
        check_word(r.word, 16'h0031, "cfg reset");
        // rate clamps at both ends
        for (int i = 0; i < 3; i++) begin
            v = (i == 0) ? 16'h0000 : (i == 1) ? 16'hffff : 16'($random(seed));
            cmd(CMD_SET_RATE, v, POINT_MIN, CHAR_HIGH);
            v = (v == 16'h0) ? 16'h0001 : (v > 16'h7fff) ? 16'h7fff : v;
            check_word(PEAK_RATE, v, "rate");
            read(CMD_READ_RATE);
            check_word(r.word, v, "rate read");
        end
        @(posedge CLOCK);
        ANALOG_VEL_MODE <= 1'b1;
        #1;
        check_bit(USE_PEAK_RATE, 1'b1, "analog");
        @(posedge CLOCK);
        ANALOG_VEL_MODE <= 1'b0;
        MOTION_ACTIVE <= 1'b1;
        #1;
        check_bit(USE_PEAK_RATE, 1'b0, "no stop");
        for (int k = 0; k < 2; k++) begin
            host.send(k ? CMD_HALT_KILL : CMD_HALT, 16'h0, POINT_MIN, CHAR_HIGH);
            #1;
            check_bit(HALT_PULSE, 1'b1, "halt");
            check_bit(KILL_PULSE, k[0], "kill");
            @(posedge CLOCK);
            #1;
            check_bit(HALT_PULSE, 1'b0, "halt one");
            check_bit(USE_PEAK_RATE, 1'b1, "stop rate");
        end
        @(posedge CLOCK);
        MOTION_ACTIVE <= 1'b0;
        FEED_ACTIVE <= 1'b1;
        repeat (3) @(posedge CLOCK);
        #1;
        check_bit(USE_PEAK_RATE, 1'b0, "stopped");
        @(posedge CLOCK);
        MOTION_ACTIVE <= 1'b1;
        raise(16'h0004);
        check_bit(USE_PEAK_RATE, 1'b1, "limit");
        @(posedge CLOCK);
        FEED_ACTIVE <= 1'b0;
        MOTION_ACTIVE <= 1'b0;
        raise(16'h0000);
        // host sets all points to outputs before any pin function
        cmd(CMD_SET_IO_DIR, 16'h000f, POINT_MIN, CHAR_HIGH);
        check_word({12'h0, IO_OE}, 16'h000f, "dir");
        cmd(CMD_SET_OUT_LEVEL, 16'h0, 3'h4, CHAR_LOW);
        check_bit(IO_OUT[3], 1'b0, "level L");
        cmd(CMD_SET_OUT_LEVEL, 16'h0, 3'h4, 8'h58);
        check_bit(IO_OUT[3], 1'b0, "bad char");
        cmd(CMD_SET_OUT_LEVEL, 16'h0, 3'h4, CHAR_HIGH);
        check_bit(IO_OUT[3], 1'b1, "level H");
        for (int f = 0; f < 4; f++) begin
            v = 16'($random(seed));
            @(posedge CLOCK);
            BRAKE_LEVEL <= v[0];
            MOTION_ACTIVE <= v[1];
            TACH_LEVEL <= v[2];
            cmd(f == 0 ? CMD_SET_BRAKE_FUNC : f == 1 ? CMD_SET_TRAVEL_FUNC :
                f == 2 ? CMD_SET_TACH_FUNC : CMD_SET_GENERAL_FUNC, 16'h0, 3'h4, CHAR_HIGH);
            check_bit(IO_OUT[3], f == 0 ? ~v[0] : f == 1 ? ~v[1] : f == 2 ? v[2] : 1'b1,
                "function");
        end
        // non-fault alarms, reserved bits driven too
        for (int i = 0; i < 3; i++) begin
            raise(16'($random(seed)) & 16'hfe46);
            check_all();
        end
        cmd(CMD_DRIVE_ENABLE, 16'h0, POINT_MIN, CHAR_HIGH);
        en = 1'b1;
        cmd(CMD_SET_PIN_CONFIG, 16'h0001, 3'h2, CHAR_HIGH);
        check_bit(IO_OUT[1], 1'b1, "code 1 idle");
        cmd(CMD_SET_PIN_CONFIG, 16'h0002, 3'h2, CHAR_HIGH);
        check_bit(IO_OUT[1], 1'b0, "code 2 idle");
        // over temperature always present so the clear meets a live alarm
        raise((16'($random(seed)) & 16'h01b9) | 16'h0088);
        check_all();
        check_bit(IO_OUT[1], 1'b1, "code 2 fault");
        cmd(CMD_SET_PIN_CONFIG, 16'h0001, 3'h2, CHAR_HIGH);
        check_bit(IO_OUT[1], 1'b0, "code 1 fault");
        cmd(CMD_SET_PIN_CONFIG, 16'h0002, 3'h5, CHAR_HIGH);
        cmd(CMD_SET_PIN_CONFIG, 16'h0000, 3'h2, CHAR_HIGH);
        cmd(CMD_SET_TACH_FUNC, 16'h0000, 3'h2, CHAR_HIGH);
        check_bit(IO_OUT[1], 1'b0, "refused");
        read(CMD_READ_PIN_CONFIG);
        check_word(r.word, 16'h0012, "cfg");
        cmd(CMD_DRIVE_ENABLE, 16'h0, POINT_MIN, CHAR_HIGH);
        cmd(CMD_FAULT_CLEAR, 16'h0, POINT_MIN, CHAR_HIGH);
        ew = ew & ALARM_COND;
        check_all();
        raise(16'h0000);
        check_all();
        cmd(CMD_FAULT_CLEAR, 16'h0, POINT_MIN, CHAR_HIGH);
        ew = 16'h0;
        check_all();
        check_bit(IO_OUT[1], 1'b1, "code 1 clear");
        cmd(CMD_SET_TRAVEL_FUNC, 16'h0, 3'h2, CHAR_HIGH);
        read(CMD_READ_PIN_CONFIG);
        check_word(r.word & 16'h00f0, 16'h0030, "reclaimed");
        check_bit(IO_OUT[1], ~MOTION_ACTIVE, "travel");
        // code 3 hands an alarm-owned point back to general use
        cmd(CMD_SET_PIN_CONFIG, 16'h0002, 3'h2, CHAR_HIGH);
        check_bit(IO_OUT[1], 1'b0, "code 2 again");
        cmd(CMD_SET_PIN_CONFIG, 16'h0003, 3'h2, CHAR_HIGH);
        check_bit(IO_OUT[1], 1'b1, "code 3 free");
        read(CMD_READ_PIN_CONFIG);
        check_word(r.word, 16'h0032, "cfg free");
        report_and_stop();
    end
endmodule
